// >>> hdl/fcb_pkg.sv
package fcb_pkg;
   // clock and flash pin timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_SETUP_NS = 20;
   localparam int T_WP_NS = 50;
   localparam int T_ACC_NS = 150;
   localparam int T_HOLD_NS = 20;
   localparam int T_RP_LOW_NS = 100;
   localparam int T_PHQV_NS = 300;
   localparam int T_SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_RP_LOW_CYC = (T_RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_PHQV_CYC = (T_PHQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // flash commands
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   // flash status bits
   localparam int SR_READY = 7;
   localparam int SR_SUSPENDED = 6;
   localparam int SR_ERASE_FAIL = 5;
   localparam int SR_PROGRAM_FAIL = 4;
   localparam int SR_SUPPLY_LOW = 3;
   localparam logic [7:0] SR_ACC_MASK = 8'h38;

   // flash geometry (word-wide part)
   localparam int FL_AW = 17;
   localparam int BLK_LSB = 12;

   // APB register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam int CTRL_ERASE = 0;
   localparam int CTRL_SUSPEND = 1;
   localparam int CTRL_RESUME = 2;
   localparam int CTRL_CLEAR = 3;
   localparam int CTRL_READ = 4;
   localparam int CTRL_RESET = 5;
   localparam int ST_BUSY = 16;
   localparam int ST_SUSP = 17;
   localparam int ST_REFUSED = 18;
   localparam int ST_DONE = 19;
   localparam int ST_SEQERR = 20;
   localparam int ST_ARRAY = 21;

   typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fcb_bus_t;
   typedef enum {S_RST_LOW, S_RST_REC, S_IDLE, S_ESETUP, S_ECONF, S_POLL, S_SUSP_CMD,
                 S_SUSPENDED, S_RESUME, S_CLR, S_RDARR_CMD, S_RDARR_RD} fcb_state_t;
endpackage : fcb_pkg

// >>> hdl/fcb_bus_cycle.sv
`timescale 1ns/10ps
module fcb_bus_cycle import fcb_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic wr,
   input wire logic [FL_AW-1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] dq_i,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [FL_AW-1:0] addr_o,
   output logic [15:0] dq_o,
   output logic dq_oe,
   output logic done,
   output logic [15:0] rdata
);
   fcb_bus_t st_r;
   logic [7:0] cnt_r;
   logic wr_r;

   // one asynchronous bus cycle; chip select released after every cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= B_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         addr_o <= '0;
         dq_o <= 16'h0000;
         dq_oe <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         done <= 1'b0;
         case (st_r)
            B_IDLE: begin
               if (start) begin
                  wr_r <= wr;
                  addr_o <= addr;
                  dq_o <= wdata;
                  dq_oe <= wr;
                  ce_n <= 1'b0;
                  cnt_r <= 8'h00;
                  st_r <= B_SETUP;
               end
            end
            B_SETUP: begin
               if (cnt_r == 8'(T_SETUP_CYC - 1)) begin
                  cnt_r <= 8'h00;
                  we_n <= !wr_r;
                  oe_n <= wr_r;
                  st_r <= B_STROBE;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            B_STROBE: begin
               if (cnt_r == (wr_r ? 8'(T_WP_CYC - 1) : 8'(T_ACC_CYC - 1))) begin
                  if (!wr_r) begin
                     rdata <= dq_i;
                  end
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  cnt_r <= 8'h00;
                  st_r <= B_HOLD;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            B_HOLD: begin
               if (cnt_r == 8'(T_HOLD_CYC - 1)) begin
                  ce_n <= 1'b1;
                  dq_oe <= 1'b0;
                  done <= 1'b1;
                  st_r <= B_IDLE;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            default: st_r <= B_IDLE;
         endcase
      end
   end

   a_we_with_ce: assert property (@(posedge clk) disable iff (!rst_n) !we_n |-> !ce_n)
      else $error("write strobe low without chip select");
   a_poll_release: assert property (@(posedge clk) disable iff (!rst_n)
      done |-> ce_n && oe_n && we_n ##1 ce_n)
      else $error("strobes not released between cycles");
   a_write_width: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(we_n) |-> (!we_n && !ce_n && dq_oe) [*8])
      else $error("write pulse too short");
endmodule : fcb_bus_cycle

// >>> hdl/fcb_erase_ctrl.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - erase is 20H then D0H inside block
// - no erase retry until bit 3 cleared
// - write FFH before reading array again
// - toggle strobes on every status poll
// - suspended: read others, status, resume only
////////////////////////////////////////////////////////////////////////////////
module fcb_erase_ctrl import fcb_pkg::*; (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic FL_CE_N,
   output logic FL_OE_N,
   output logic FL_WE_N,
   output logic [FL_AW-1:0] FL_ADDR,
   output logic [15:0] FL_DQ_O,
   output logic FL_DQ_OE,
   input wire logic [15:0] FL_DQ_I,
   output logic FL_POWERDOWN_RESET_N
);
   fcb_state_t st_r;
   logic [7:0] cnt_r;
   logic issued_r;
   logic [4:0] blk_r;
   logic [FL_AW-1:0] addr_r;
   logic [7:0] sr_r;
   logic [7:0] acc_r;
   logic mode_array_r;
   logic in_susp_r;
   logic susp_req_r;
   logic susp_wait_r;
   logic refused_r;
   logic done_r;
   logic [15:0] rdata_r;
   logic [7:0] since_pdr_r;
   logic ctrl_wr;
   logic req_erase;
   logic req_susp;
   logic req_resume;
   logic req_clear;
   logic req_read;
   logic req_rst;
   logic rst_pend_r;
   logic rst_go;
   logic needs_bus;
   logic bus_go;
   logic bus_wr;
   logic [FL_AW-1:0] bus_addr;
   logic [15:0] bus_data;
   logic bus_done;
   logic [15:0] bus_rdata;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign ctrl_wr = PSEL && PENABLE && PWRITE && (PADDR == REG_CTRL);
   assign req_erase = ctrl_wr && PWDATA[CTRL_ERASE];
   assign req_susp = ctrl_wr && PWDATA[CTRL_SUSPEND];
   assign req_resume = ctrl_wr && PWDATA[CTRL_RESUME];
   assign req_clear = ctrl_wr && PWDATA[CTRL_CLEAR];
   assign req_read = ctrl_wr && PWDATA[CTRL_READ];
   assign req_rst = ctrl_wr && PWDATA[CTRL_RESET];

   assign status_word = {10'h000, mode_array_r, acc_r[SR_PROGRAM_FAIL] & acc_r[SR_ERASE_FAIL],
                         done_r, refused_r, st_r == S_SUSPENDED,
                         (st_r != S_IDLE) && (st_r != S_SUSPENDED), acc_r, sr_r};

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= 1'b1;
         if (PSEL && !PENABLE) begin
            PSLVERR <= (PADDR != REG_CTRL) && (PADDR != REG_ADDR) && (PADDR != REG_STATUS) &&
                       (PADDR != REG_RDATA);
            case (PADDR)
               REG_ADDR: PRDATA <= {15'h0000, addr_r};
               REG_STATUS: PRDATA <= status_word;
               REG_RDATA: PRDATA <= {16'h0000, rdata_r};
               default: PRDATA <= 32'h00000000;
            endcase
         end
      end
   end

   // address may only change while no flash operation is running
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         addr_r <= '0;
      end else if (PSEL && PENABLE && PWRITE && (PADDR == REG_ADDR) &&
                   (st_r == S_IDLE || st_r == S_SUSPENDED)) begin
         addr_r <= PWDATA[FL_AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus request per state
   always_comb begin
      bus_wr = 1'b1;
      needs_bus = 1'b1;
      bus_data = 16'h0000;
      bus_addr = {blk_r, 12'h000};
      case (st_r)
         S_ESETUP: bus_data = {8'h00, CMD_ERASE_SETUP};
         S_ECONF: bus_data = {8'h00, CMD_CONFIRM};
         S_RESUME: bus_data = {8'h00, CMD_CONFIRM};
         S_SUSP_CMD: bus_data = {8'h00, CMD_SUSPEND};
         S_CLR: bus_data = {8'h00, CMD_CLEAR_STATUS};
         S_RDARR_CMD: bus_data = {8'h00, CMD_READ_ARRAY};
         S_POLL: bus_wr = 1'b0;
         S_RDARR_RD: begin
            bus_wr = 1'b0;
            bus_addr = addr_r;
         end
         default: needs_bus = 1'b0;
      endcase
   end
   assign bus_go = needs_bus && !issued_r && !req_rst && !rst_pend_r;

   // flash reset waits for the running bus cycle, so no strobe overlaps the low pin
   assign rst_go = (req_rst || rst_pend_r) && (!issued_r || bus_done);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_pend_r <= 1'b0;
      end else begin
         rst_pend_r <= (req_rst || rst_pend_r) && !rst_go;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         issued_r <= 1'b0;
      end else if (rst_go || bus_done) begin
         issued_r <= 1'b0;
      end else if (bus_go) begin
         issued_r <= 1'b1;
      end
   end

   fcb_bus_cycle u_bus (
      .clk(CLOCK),
      .rst_n(RST_N),
      .start(bus_go),
      .wr(bus_wr),
      .addr(bus_addr),
      .wdata(bus_data),
      .dq_i(FL_DQ_I),
      .ce_n(FL_CE_N),
      .oe_n(FL_OE_N),
      .we_n(FL_WE_N),
      .addr_o(FL_ADDR),
      .dq_o(FL_DQ_O),
      .dq_oe(FL_DQ_OE),
      .done(bus_done),
      .rdata(bus_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // reset pin: low from controller reset, high only after the low time
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         FL_POWERDOWN_RESET_N <= 1'b0;
         since_pdr_r <= 8'h00;
      end else begin
         FL_POWERDOWN_RESET_N <= (st_r != S_RST_LOW);
         if (!FL_POWERDOWN_RESET_N) begin
            since_pdr_r <= 8'h00;
         end else if (since_pdr_r != 8'hFF) begin
            since_pdr_r <= since_pdr_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // erase sequencer
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= S_RST_LOW;
         cnt_r <= 8'h00;
         blk_r <= 5'h00;
         sr_r <= 8'h00;
         acc_r <= 8'h00;
         mode_array_r <= 1'b1;
         in_susp_r <= 1'b0;
         susp_req_r <= 1'b0;
         susp_wait_r <= 1'b0;
         refused_r <= 1'b0;
         done_r <= 1'b0;
         rdata_r <= 16'h0000;
      end else if (rst_go) begin
         st_r <= S_RST_LOW;
         cnt_r <= 8'h00;
      end else begin
         case (st_r)
            S_RST_LOW: begin
               sr_r <= 8'h00;
               acc_r <= 8'h00;
               mode_array_r <= 1'b1;
               in_susp_r <= 1'b0;
               susp_req_r <= 1'b0;
               susp_wait_r <= 1'b0;
               if (cnt_r == 8'(T_RP_LOW_CYC - 1)) begin
                  cnt_r <= 8'h00;
                  st_r <= S_RST_REC;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            S_RST_REC: begin
               if (cnt_r == 8'(T_PHQV_CYC)) begin
                  st_r <= S_IDLE;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            S_IDLE: begin
               if (req_erase) begin
                  if (acc_r[SR_SUPPLY_LOW]) begin
                     refused_r <= 1'b1;
                  end else begin
                     blk_r <= addr_r[FL_AW-1:BLK_LSB];
                     refused_r <= 1'b0;
                     done_r <= 1'b0;
                     st_r <= S_ESETUP;
                  end
               end else if (req_clear) begin
                  refused_r <= 1'b0;
                  st_r <= S_CLR;
               end else if (req_read) begin
                  refused_r <= 1'b0;
                  st_r <= mode_array_r ? S_RDARR_RD : S_RDARR_CMD;
               end else if (req_susp || req_resume) begin
                  refused_r <= 1'b1;
               end
            end
            S_ESETUP: begin
               if (bus_done) begin
                  st_r <= S_ECONF;
               end
            end
            S_ECONF: begin
               if (bus_done) begin
                  mode_array_r <= 1'b0;
                  susp_req_r <= 1'b0;
                  st_r <= S_POLL;
               end
            end
            S_POLL: begin
               if (req_susp && !susp_wait_r) begin
                  susp_req_r <= 1'b1;
               end
               if (bus_done) begin
                  sr_r <= bus_rdata[7:0];
                  acc_r <= acc_r | (bus_rdata[7:0] & SR_ACC_MASK);
                  if (bus_rdata[SR_READY]) begin
                     susp_req_r <= 1'b0;
                     susp_wait_r <= 1'b0;
                     if (bus_rdata[SR_SUSPENDED]) begin
                        in_susp_r <= 1'b1;
                        st_r <= S_SUSPENDED;
                     end else begin
                        done_r <= 1'b1;
                        st_r <= S_IDLE;
                     end
                  end else if ((susp_req_r || req_susp) && !susp_wait_r) begin
                     st_r <= S_SUSP_CMD;
                  end
               end
            end
            S_SUSP_CMD: begin
               if (bus_done) begin
                  susp_wait_r <= 1'b1;
                  susp_req_r <= 1'b0;
                  st_r <= S_POLL;
               end
            end
            S_SUSPENDED: begin
               if (req_resume) begin
                  refused_r <= 1'b0;
                  st_r <= S_RESUME;
               end else if (req_read) begin
                  if (addr_r[FL_AW-1:BLK_LSB] == blk_r) begin
                     refused_r <= 1'b1;
                  end else begin
                     refused_r <= 1'b0;
                     st_r <= mode_array_r ? S_RDARR_RD : S_RDARR_CMD;
                  end
               end else if (req_erase || req_clear || req_susp) begin
                  refused_r <= 1'b1;
               end
            end
            S_RESUME: begin
               if (bus_done) begin
                  in_susp_r <= 1'b0;
                  mode_array_r <= 1'b0;
                  st_r <= S_POLL;
               end
            end
            S_CLR: begin
               if (bus_done) begin
                  acc_r <= 8'h00;
                  sr_r <= 8'h00;
                  mode_array_r <= 1'b0;
                  st_r <= S_IDLE;
               end
            end
            S_RDARR_CMD: begin
               if (bus_done) begin
                  mode_array_r <= 1'b1;
                  st_r <= S_RDARR_RD;
               end
            end
            S_RDARR_RD: begin
               if (bus_done) begin
                  rdata_r <= bus_rdata;
                  st_r <= in_susp_r ? S_SUSPENDED : S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_rec_before_access: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !FL_CE_N |-> FL_POWERDOWN_RESET_N && since_pdr_r >= 8'(T_PHQV_CYC))
      else $error("flash accessed before reset recovery");
   a_confirm_follows: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (st_r == S_ECONF && $past(st_r) != S_ECONF) |-> $past(st_r) == S_ESETUP)
      else $error("confirm without setup");
   a_supply_refuse: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (st_r == S_IDLE && req_erase && !rst_go && acc_r[SR_SUPPLY_LOW]) |=> st_r == S_IDLE && refused_r)
      else $error("erase retried with supply flag set");
   a_read_needs_ff: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (st_r == S_RDARR_RD && bus_go) |-> mode_array_r)
      else $error("array read without read array command");
   a_susp_other_blk: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (st_r == S_RDARR_RD && in_susp_r) |-> addr_r[FL_AW-1:BLK_LSB] != blk_r)
      else $error("read from suspended block");
   a_fail_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (acc_r[SR_ERASE_FAIL] && st_r != S_CLR && st_r != S_RST_LOW) |=> acc_r[SR_ERASE_FAIL])
      else $error("erase fail flag lost");
   a_busy_keeps_poll: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (st_r == S_POLL && bus_done && !bus_rdata[SR_READY] && !rst_go) |=> st_r == S_POLL || st_r == S_SUSP_CMD)
      else $error("left polling while busy");
   a_pin_low_time: assert property (@(posedge CLOCK) disable iff (!RST_N)
      $fell(FL_POWERDOWN_RESET_N) |-> (!FL_POWERDOWN_RESET_N && st_r != S_IDLE) [*8])
      else $error("reset pin pulse too short");
endmodule : fcb_erase_ctrl

// >>> testbench/fcb_flash_model.sv
`timescale 1ns/10ps
module fcb_flash_model import fcb_pkg::*; #(
   parameter int ERASE_CYC = 512
) (
   input wire logic clk,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rp_n,
   input wire logic [FL_AW-1:0] addr,
   input wire logic [15:0] din,
   input wire logic vpp_ok,
   input wire logic erase_bad,
   output logic [15:0] dq
);
   logic we_q, oe_q, busy, susp, sreq, stat, setup, dq_on, act;
   logic [6:0] sr;
   logic [31:0] erased = 32'h0;
   logic [4:0] blk;
   logic [15:0] out_r, last_r;
   int cnt, rec;
   assign act = rp_n && rec == 0;
   assign dq_on = act && !ce_n && !oe_n;
   assign dq = dq_on ? out_r : ~last_r;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or negedge rp_n) begin
      if (!rp_n) begin
         {we_q, oe_q, busy, susp, sreq, stat, setup} <= 7'b1100000;
         sr <= 7'h00;
         rec <= 60;
         cnt <= 0;
         last_r <= 16'h0000;
      end else begin
         we_q <= we_n;
         oe_q <= oe_n;
         if (dq_on) last_r <= out_r;
         if (rec != 0) rec <= rec - 1;
         // one phase of ERASE_CYC cycles, suspend taken when cnt is a multiple of 64, timed here alone
         if (busy) begin
            cnt <= cnt + 1;
            if (sreq && cnt % 64 == 0) begin
               {busy, susp, sreq} <= 3'b010;
               sr[6] <= 1'b1;
            end else if (cnt == ERASE_CYC - 1) begin
               busy <= 1'b0;
               erased[blk] <= !erase_bad;
               if (erase_bad) sr[5] <= 1'b1;
            end
         end
         if (oe_q && !oe_n && !ce_n) begin
            out_r <= stat ? {8'h00, !busy, sr} : (erased[addr[16:12]] ? 16'hFFFF : addr[15:0] ^ 16'h5A5A);
         end
         if (act && !we_q && we_n && !ce_n) begin
            if (busy) begin
               if (din[7:0] == CMD_SUSPEND) sreq <= 1'b1;
            end else if (susp) begin
               if (din[7:0] == CMD_CONFIRM) begin
                  {susp, busy, stat} <= 3'b011;
                  sr[6] <= 1'b0;
               end else if (din[7:0] == CMD_READ_ARRAY) stat <= 1'b0;
               else if (din[7:0] == 8'h70) stat <= 1'b1;
            end else if (setup) begin
               {setup, stat} <= 2'b01;
               if (din[7:0] != CMD_CONFIRM) sr[5:4] <= 2'b11;
               else if (!vpp_ok) {sr[5], sr[3]} <= 2'b11;
               else if (!sr[3]) begin
                  {busy, cnt} <= {1'b1, 32'd0};
                  blk <= addr[16:12];
               end
            end else begin
               case (din[7:0])
                  CMD_ERASE_SETUP: setup <= 1'b1;
                  CMD_READ_ARRAY: stat <= 1'b0;
                  CMD_CLEAR_STATUS: sr[5:3] <= 3'b000;
                  default: stat <= 1'b1;
               endcase
            end
         end
      end
   end
endmodule : fcb_flash_model

// >>> testbench/fcb_erase_ctrl_tb_top.sv
`timescale 1ns/10ps
module fcb_erase_ctrl_tb_top import fcb_pkg::*;;
   `define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
   logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, vpp_ok = 1, erase_bad = 0;
   logic FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, FL_POWERDOWN_RESET_N;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rq, r;
   logic [FL_AW-1:0] FL_ADDR;
   logic [15:0] FL_DQ_O, FL_DQ_I, mdq;
   logic [32:0] eq[$], mq[$];
   logic [32:0] e1, m1;
   int mismatches = 0, check_count = 0, cyc = 0;
   always #2.5 CLOCK = ~CLOCK;
   assign FL_DQ_I = FL_DQ_OE ? FL_DQ_O : mdq;
   fcb_erase_ctrl DUT (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
      .FL_DQ_OE(FL_DQ_OE), .FL_DQ_I(FL_DQ_I), .FL_POWERDOWN_RESET_N(FL_POWERDOWN_RESET_N));
   fcb_flash_model u_flash (.clk(CLOCK), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
      .rp_n(FL_POWERDOWN_RESET_N), .addr(FL_ADDR), .din(FL_DQ_O), .vpp_ok(vpp_ok), .erase_bad(erase_bad), .dq(mdq));
   ////////////////////////////////////////////////////////////////////////////////
   task final_report;
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 100000) begin
         mismatches++;
         final_report;
      end
   end
   // read monitor: oldest note against what the slave returns
   always @(posedge CLOCK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
         if (eq.size() == 0) `CHK("note", 1'b1, 1'b0)
         else begin
            e1 = eq.pop_front();
            m1 = mq.pop_front();
            `CHK("read", e1, {PSLVERR, PRDATA} & m1)
         end
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rq = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      eq.push_back({!(a inside {REG_CTRL, REG_ADDR, REG_STATUS, REG_RDATA}), e & m});
      mq.push_back({1'b1, m});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic poll(input int b, input logic v);
      int t;
      t = 0;
      do rd(REG_STATUS, 32'h0, 32'h0); while (rq[b] !== v && ++t < 3000);
      `CHK("poll", v, rq[b])
   endtask : poll
   task automatic cmd(input int b);
      apb(1'b1, REG_CTRL, 32'h1 << b);
      repeat (8) @(posedge CLOCK);
      if (b != CTRL_SUSPEND && b != CTRL_RESUME) poll(ST_BUSY, 1'b0);
   endtask : cmd
   task automatic at(input logic [4:0] b, input int c);
      r = $urandom();
      apb(1'b1, REG_ADDR, {15'h0, b, r[11:0]});
      cmd(c);
   endtask : at
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      r = $urandom(32'h837e);
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      poll(ST_BUSY, 1'b0);
      rd(REG_STATUS, 32'h0020_0000, 32'h0021_0000);
      rd(8'h10, 32'h0, 32'h0);
      cmd(CTRL_SUSPEND);
      rd(REG_STATUS, 32'h0004_0000, 32'h0005_0000);
      at(5'h03, CTRL_ERASE);
      rd(REG_STATUS, 32'h0008_0080, 32'h0008_38B8);
      at(5'h03, CTRL_READ);
      rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
      at(5'h05, CTRL_READ);
      rd(REG_RDATA, {16'h0, {4'h5, r[11:0]} ^ 16'h5A5A}, 32'hFFFF);
      erase_bad <= 1'b1;
      at(5'h07, CTRL_ERASE);
      rd(REG_STATUS, 32'h2020, 32'h2020);
      erase_bad <= 1'b0;
      at(5'h08, CTRL_ERASE);
      rd(REG_STATUS, 32'h20A0, 32'h20A0);
      cmd(CTRL_CLEAR);
      rd(REG_STATUS, 32'h0, 32'h3800);
      vpp_ok <= 1'b0;
      at(5'h09, CTRL_ERASE);
      rd(REG_STATUS, 32'h2828, 32'h2828);
      vpp_ok <= 1'b1;
      at(5'h09, CTRL_ERASE);
      rd(REG_STATUS, 32'h0004_0000, 32'h0004_0000);
      cmd(CTRL_CLEAR);
      at(5'h09, CTRL_ERASE);
      rd(REG_STATUS, 32'h0008_0000, 32'h000C_3800);
      at(5'h0A, CTRL_ERASE - 0);
      at(5'h0B, CTRL_ERASE);
      cmd(CTRL_CLEAR);
      r = $urandom();
      apb(1'b1, REG_ADDR, {15'h0, 5'h0C, r[11:0]});
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_ERASE);
      repeat (150) @(posedge CLOCK);
      cmd(CTRL_SUSPEND);
      poll(ST_SUSP, 1'b1);
      rd(REG_STATUS, 32'h0002_00C0, 32'h0002_00C0);
      at(5'h0D, CTRL_READ);
      rd(REG_RDATA, {16'h0, {4'hD, r[11:0]} ^ 16'h5A5A}, 32'hFFFF);
      at(5'h0C, CTRL_READ);
      rd(REG_STATUS, 32'h0006_0000, 32'h0006_0000);
      cmd(CTRL_RESUME);
      poll(ST_SUSP, 1'b0);
      poll(ST_BUSY, 1'b0);
      rd(REG_STATUS, 32'h0008_0080, 32'h000A_00E0);
      at(5'h0C, CTRL_READ);
      rd(REG_RDATA, 32'hFFFF, 32'hFFFF);
      r = $urandom();
      apb(1'b1, REG_ADDR, {15'h0, 5'h0E, r[11:0]});
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_ERASE);
      repeat (150) @(posedge CLOCK);
      cmd(CTRL_RESET);
      rd(REG_STATUS, 32'h0, 32'h3800);
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_READ);
      repeat (8) @(posedge CLOCK);
      poll(ST_BUSY, 1'b0);
      rd(REG_RDATA, {16'h0, {4'hE, r[11:0]} ^ 16'h5A5A}, 32'hFFFF);
      final_report;
   end
endmodule : fcb_erase_ctrl_tb_top
